// [common/spr_pkg.sv]
// Constants, field layout and types for the synthesizer program registers
package spr_pkg;
    localparam int WORD_W = 24;
    localparam int SEL_W = 3;
    typedef enum logic [2:0] {
        SEL_CHANNEL = 3'h0,
        SEL_MODREF = 3'h1,
        SEL_PHASE = 3'h2,
        SEL_FUNC = 3'h3,
        SEL_PUMP = 3'h4,
        SEL_PWRDN = 3'h5,
        SEL_OUTMUX = 3'h6,
        SEL_TEST = 3'h7
    } spr_sel_t;
    // Channel word
    localparam int FRACTION_NUMERATOR_LSB = 3;
    localparam int FRACTION_NUMERATOR_W = 12;
    localparam int INT_LSB = 15;
    localparam int INT_W = 8;
    // Modulus and reference word
    localparam int MOD_LSB = 3;
    localparam int MOD_W = 12;
    localparam int RCNT_LSB = 15;
    localparam int RCNT_W = 4;
    localparam int DBL_BIT = 19;
    localparam int PRESC_BIT = 20;
    localparam int HALF_BIT = 22;
    localparam int BOOST_BIT = 23;
    // Phase word
    localparam int PHASE_LSB = 3;
    localparam int PHASE_W = 12;
    // Pump timeout word
    localparam int TSEL_LSB = 3;
    localparam int TMR_LSB = 5;
    localparam int TMR_W = 9;
    typedef enum logic [1:0] {
        TSEL_SW1 = 2'h0,
        TSEL_SW2 = 2'h1,
        TSEL_ICP = 2'h2,
        TSEL_NONE = 2'h3
    } spr_tsel_t;
    // Widths of words kept raw for the rest of the chip
    localparam int FN_W = 13;
    localparam int PD_W = 5;
    localparam int MUX_W = 13;
    localparam int TST_W = 13;
    // Pump cell count, 64 cells in fast lock down to one
    localparam int CELLS_W = 7;
    localparam logic [6:0] PUMP_MAX = 7'h40;
    localparam logic [6:0] PUMP_MIN = 7'h01;
    // Timers run at a quarter of the detector rate
    localparam logic [1:0] QTR_LAST = 2'h3;
    // Reset values
    localparam logic [3:0] RST_RCNT = 4'h1;
    localparam logic [11:0] RST_MOD = 12'h00D;
    localparam logic [7:0] RST_INT = 8'h1A;
endpackage : spr_pkg

// [logic/spr_program_regs.sv]
// Program register bank with staging and fast lock timers
`timescale 1ns/100ps
module spr_program_regs
    import spr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Three-wire serial link
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic loadStrobe,
    // Reference input pin
    input wire logic referenceInput,
    // Feedback divider
    output logic [INT_W-1:0] divInt,
    output logic [FRACTION_NUMERATOR_W-1:0] divFrac,
    output logic [MOD_W-1:0] divModulus,
    output logic [PHASE_W-1:0] phaseSeed,
    output logic divLoad,
    // Reference path settings and detector tick
    output logic [RCNT_W-1:0] refCount,
    output logic refDoubler,
    output logic refHalve,
    output logic prescalerSel,
    output logic pfdTick,
    // Fast lock
    output logic [CELLS_W-1:0] pumpCells,
    output logic pumpBoost,
    output logic filterSwitchOne,
    output logic filterSwitchTwo,
    output logic filterSwitchThree,
    // Raw words for other sections
    output logic [FN_W-1:0] functionBits,
    output logic [PD_W-1:0] powerDownBits,
    output logic [MUX_W-1:0] outputMuxBits,
    output logic [TST_W-1:0] testBits
);
    typedef struct packed {
        logic [1:0] leSync;
        logic leSeen;
        logic [1:0] refSync;
        // Staged modulus, reference and phase
        logic [MOD_W-1:0] stMod;
        logic [RCNT_W-1:0] stR;
        logic stDbl;
        logic stPre;
        logic stHalf;
        logic stBoost;
        logic [PHASE_W-1:0] stPhase;
        // Active copies
        logic [MOD_W-1:0] actMod;
        logic [RCNT_W-1:0] actR;
        logic actDbl;
        logic actPre;
        logic actHalf;
        logic actBoost;
        logic [PHASE_W-1:0] actPhase;
        // Channel word waiting for a detector cycle
        logic [INT_W-1:0] newInt;
        logic [FRACTION_NUMERATOR_W-1:0] newFrac;
        logic loadPend;
        logic [INT_W-1:0] divInt;
        logic [FRACTION_NUMERATOR_W-1:0] divFrac;
        logic divLoad;
        // Timeout settings
        logic [TMR_W-1:0] tmIcp;
        logic [TMR_W-1:0] tmSw1;
        logic [TMR_W-1:0] tmSw2;
        // Raw words
        logic [FN_W-1:0] fnReg;
        logic [PD_W-1:0] pdReg;
        logic [MUX_W-1:0] muxReg;
        logic [TST_W-1:0] tstReg;
        // Fast lock state
        logic [1:0] qtr;
        logic [TMR_W-1:0] cntIcp;
        logic [TMR_W-1:0] cntSw1;
        logic [TMR_W-1:0] cntSw2;
        logic [CELLS_W-1:0] cells;
        logic sw1;
        logic sw2;
        logic sw3;
    } spr_state_t;

    spr_state_t q, d;
    logic [1:0] rstPipe;
    logic rstN;
    logic [WORD_W-1:0] shiftWord;
    logic tick;
    logic wr;
    logic tmrTick;
    spr_sel_t sel;
    spr_tsel_t tsel;

    // Reset is released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    spr_serial_shift #(
        .W(WORD_W)
    ) uShift (
        .serialClk(serialClk),
        .arst_n(arst_n),
        .serialData(serialData),
        .shiftWord(shiftWord)
    );

    // Settings come from the active copies, so they move only on a
    // channel write
    spr_ref_div #(
        .RW(RCNT_W)
    ) uRef (
        .clk(clk),
        .rst_n(rstN),
        .refLevel(q.refSync[1]),
        .doublerEn(q.actDbl),
        .halveEn(q.actHalf),
        .rCount(q.actR),
        .pfdTick(tick)
    );

    // The shifted word is read only after the strobe has crossed two
    // flops; the host keeps the link clock still meanwhile, so the word
    // is static when sampled here.
    assign wr = q.leSync[1] & ~q.leSeen;
    assign sel = spr_sel_t'(shiftWord[SEL_W-1:0]);
    assign tsel = spr_tsel_t'(shiftWord[TSEL_LSB +: 2]);
    assign tmrTick = tick & (q.qtr == QTR_LAST);

    always_comb begin
        d = q;
        d.divLoad = 1'b0;
        d.leSync = {q.leSync[0], loadStrobe};
        d.leSeen = q.leSync[1];
        d.refSync = {q.refSync[0], referenceInput};
        if (tick) begin
            d.qtr = q.qtr + 2'h1;
        end
        // Timers count down at a quarter of the detector rate
        if (tmrTick) begin
            if (q.cntIcp != '0) begin
                d.cntIcp = q.cntIcp - TMR_W'(1);
            end else if (q.cells > PUMP_MIN) begin
                // Cells drop in binary steps after the pump timeout
                d.cells = q.cells >> 1;
            end
            if (q.cntSw1 != '0) begin
                d.cntSw1 = q.cntSw1 - TMR_W'(1);
            end
            if (q.cntSw2 != '0) begin
                d.cntSw2 = q.cntSw2 - TMR_W'(1);
            end
        end
        // Divider takes the new channel on the next detector cycle
        if (q.loadPend && tick) begin
            d.divInt = q.newInt;
            d.divFrac = q.newFrac;
            d.divLoad = 1'b1;
            d.loadPend = 1'b0;
            d.cntIcp = q.tmIcp;
            d.cntSw1 = q.tmSw1;
            d.cntSw2 = q.tmSw2;
            d.cells = PUMP_MAX;
            d.qtr = 2'h0;
        end
        // A write after the tick wins, so a fresh word is never lost
        if (wr) begin
            unique case (sel)
                SEL_CHANNEL: begin
                    d.newInt = shiftWord[INT_LSB +: INT_W];
                    d.newFrac = shiftWord[FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W];
                    d.loadPend = 1'b1;
                    d.actMod = q.stMod;
                    d.actR = q.stR;
                    d.actDbl = q.stDbl;
                    d.actPre = q.stPre;
                    d.actHalf = q.stHalf;
                    d.actBoost = q.stBoost;
                    d.actPhase = q.stPhase;
                end
                SEL_MODREF: begin
                    d.stMod = shiftWord[MOD_LSB +: MOD_W];
                    d.stR = shiftWord[RCNT_LSB +: RCNT_W];
                    d.stDbl = shiftWord[DBL_BIT];
                    d.stPre = shiftWord[PRESC_BIT];
                    d.stHalf = shiftWord[HALF_BIT];
                    d.stBoost = shiftWord[BOOST_BIT];
                end
                SEL_PHASE: begin
                    d.stPhase = shiftWord[PHASE_LSB +: PHASE_W];
                end
                SEL_FUNC: begin
                    d.fnReg = shiftWord[SEL_W +: FN_W];
                end
                SEL_PUMP: begin
                    unique case (tsel)
                        TSEL_SW1: d.tmSw1 = shiftWord[TMR_LSB +: TMR_W];
                        TSEL_SW2: d.tmSw2 = shiftWord[TMR_LSB +: TMR_W];
                        TSEL_ICP: d.tmIcp = shiftWord[TMR_LSB +: TMR_W];
                        TSEL_NONE: begin
                        end
                    endcase
                end
                SEL_PWRDN: begin
                    d.pdReg = shiftWord[SEL_W +: PD_W];
                end
                SEL_OUTMUX: begin
                    d.muxReg = shiftWord[SEL_W +: MUX_W];
                end
                SEL_TEST: begin
                    d.tstReg = shiftWord[SEL_W +: TST_W];
                end
            endcase
        end
        // Switches stay closed while their timers run; the third one
        // shares the second timer since only two switch timers exist
        d.sw1 = d.cntSw1 != '0;
        d.sw2 = d.cntSw2 != '0;
        d.sw3 = d.cntSw2 != '0;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
            q.cells <= PUMP_MIN;
            q.stR <= RST_RCNT;
            q.actR <= RST_RCNT;
            q.stMod <= RST_MOD;
            q.actMod <= RST_MOD;
            q.newInt <= RST_INT;
            q.divInt <= RST_INT;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign divInt = q.divInt;
    assign divFrac = q.divFrac;
    assign divModulus = q.actMod;
    assign phaseSeed = q.actPhase;
    assign divLoad = q.divLoad;
    assign refCount = q.actR;
    assign refDoubler = q.actDbl;
    assign refHalve = q.actHalf;
    assign prescalerSel = q.actPre;
    assign pfdTick = tick;
    assign pumpCells = q.cells;
    assign pumpBoost = q.actBoost;
    assign filterSwitchOne = q.sw1;
    assign filterSwitchTwo = q.sw2;
    assign filterSwitchThree = q.sw3;
    assign functionBits = q.fnReg;
    assign powerDownBits = q.pdReg;
    assign outputMuxBits = q.muxReg;
    assign testBits = q.tstReg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);

    a_strobe_write: assert property (
        $rose(q.leSync[1]) |-> wr ##1 !wr
    ) else $error("strobe rise did not give one write");

    a_select_phase: assert property (
        wr && sel == SEL_PHASE
        |=> q.stPhase == $past(shiftWord[PHASE_LSB +: PHASE_W])
    ) else $error("phase word not stored on select 2");

    a_channel_fields: assert property (
        wr && sel == SEL_CHANNEL
        |=> q.newInt == $past(shiftWord[INT_LSB +: INT_W])
            && q.newFrac == $past(shiftWord[FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W])
    ) else $error("channel fields taken from wrong bits");

    a_retune_pend: assert property (
        wr && sel == SEL_CHANNEL |=> q.loadPend
    ) else $error("channel write did not arm a retune");

    a_divider_load: assert property (
        q.loadPend && tick
        |=> divLoad && divInt == $past(q.newInt)
            && divFrac == $past(q.newFrac)
    ) else $error("divider not loaded on detector cycle");

    a_no_early_load: assert property (
        !q.loadPend |=> !divLoad
    ) else $error("divider loaded without a pending word");

    a_fast_start: assert property (
        divLoad |-> pumpCells == PUMP_MAX && q.cntIcp == q.tmIcp
            && filterSwitchOne == (q.tmSw1 != '0)
    ) else $error("fast lock did not start with full pump");

    a_pump_step: assert property (
        tmrTick && q.cntIcp == '0 && q.cells > PUMP_MIN && !q.loadPend
        |=> pumpCells == ($past(q.cells) >> 1)
    ) else $error("pump cells did not halve after timeout");

    a_pump_hold: assert property (
        q.cntIcp != '0 && !(q.loadPend && tick)
        |=> pumpCells == $past(pumpCells)
    ) else $error("pump current left maximum before its timeout");

    a_switch_timeout: assert property (
        tmrTick && q.cntSw1 == TMR_W'(1) && !q.loadPend
        |=> !filterSwitchOne
    ) else $error("switch one still closed after its timeout");

    a_stage_hold: assert property (
        wr && sel == SEL_MODREF
        |=> divModulus == $past(divModulus) && pumpBoost == $past(pumpBoost)
    ) else $error("staged value applied before channel write");

    a_stage_apply: assert property (
        wr && sel == SEL_CHANNEL
        |=> pumpBoost == $past(q.stBoost) && refHalve == $past(q.stHalf)
    ) else $error("staged value not applied on channel write");

    a_stage_latest: assert property (
        wr && sel == SEL_MODREF
        |=> q.stMod == $past(shiftWord[MOD_LSB +: MOD_W])
    ) else $error("newer staged word did not replace older one");

    c_channel_write: cover property (wr && sel == SEL_CHANNEL);
    c_staged_retune: cover property (
        wr && sel == SEL_MODREF ##[1:200] wr && sel == SEL_CHANNEL
    );
    c_pump_settled: cover property (
        $fell(q.cells > PUMP_MIN) && q.cntIcp == '0
    );
    c_switch_open: cover property ($fell(filterSwitchOne));
endmodule : spr_program_regs

// [logic/spr_ref_div.sv]
// Reference path: doubler, reference counter and halving stage
`timescale 1ns/100ps
module spr_ref_div
    import spr_pkg::*;
#(
    parameter int RW = RCNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised reference level and settings
    input wire logic refLevel,
    input wire logic doublerEn,
    input wire logic halveEn,
    input wire logic [RW-1:0] rCount,
    // Detector comparison tick
    output logic pfdTick
);
    typedef struct packed {
        logic refPrev;
        logic [RW-1:0] cnt;
        logic halfT;
        logic tick;
    } spr_ref_st_t;

    spr_ref_st_t q, d;
    logic refEdge;
    logic fire;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.refPrev = refLevel;
        fire = 1'b0;
        // Doubling counts both edges of the reference
        if (doublerEn) begin
            refEdge = refLevel ^ q.refPrev;
        end else begin
            refEdge = refLevel & ~q.refPrev;
        end
        if (refEdge) begin
            // Zero is taken as divide by one
            if (q.cnt + RW'(1) >= rCount) begin
                d.cnt = '0;
                fire = 1'b1;
            end else begin
                d.cnt = q.cnt + RW'(1);
            end
        end
        if (fire) begin
            if (halveEn) begin
                d.halfT = ~q.halfT;
                d.tick = q.halfT;
            end else begin
                d.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pfdTick = q.tick;
endmodule : spr_ref_div

// [logic/spr_serial_shift.sv]
// Serial input shift register on the link clock
`timescale 1ns/100ps
module spr_serial_shift
    import spr_pkg::*;
#(
    parameter int W = WORD_W
) (
    // Link side
    input wire logic serialClk,
    input wire logic arst_n,
    input wire logic serialData,
    // Shifted word, static once the link clock stops
    output logic [W-1:0] shiftWord
);
    typedef struct packed {
        logic [W-1:0] sr;
    } spr_shift_st_t;

    spr_shift_st_t q, d;

    always_comb begin
        d = q;
        d.sr = {q.sr[W-2:0], serialData};
    end

    // Reset only clears; the link clock may be stopped at release
    always_ff @(posedge serialClk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign shiftWord = q.sr;
endmodule : spr_serial_shift

// [test/spr_host_model.sv]
// Host controller model driving the three-wire programming link
`timescale 1ns/100ps
module spr_host_model (
    // Three-wire serial link
    output logic serialClk,
    output logic serialData,
    output logic loadStrobe
);
    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        loadStrobe = 1'b0;
    end

    // Link clock runs only inside a frame; idle data shows the inverse of
    // the last bit so a stale value can never pass for a fresh one
    task automatic sendWord(input logic [23:0] w);
        #1.7;
        for (int i = 23; i >= 0; i--) begin
            serialData = w[i];
            #3 serialClk = 1'b1;
            #3 serialClk = 1'b0;
        end
        serialData = ~w[0];
        // Strobe high 20 ns and low 24 ns keeps the spacing the sync needs
        #2 loadStrobe = 1'b1;
        #20 loadStrobe = 1'b0;
        #24;
    endtask : sendWord
endmodule : spr_host_model

// [test/testbench.sv]
// Self-checking bench for the synthesizer program register bank
`timescale 1ns/100ps
module testbench;
    import spr_pkg::*;
    localparam int LIMIT = 30000;
    logic clk, arst_n, serialClk, serialData, loadStrobe;
    logic referenceInput = 1'b0;
    logic [INT_W-1:0] divInt;
    logic [FRACTION_NUMERATOR_W-1:0] divFrac;
    logic [MOD_W-1:0] divModulus;
    logic [PHASE_W-1:0] phaseSeed;
    logic divLoad, refDoubler, refHalve, prescalerSel, pfdTick, pumpBoost;
    logic [RCNT_W-1:0] refCount;
    logic [CELLS_W-1:0] pumpCells;
    logic filterSwitchOne, filterSwitchTwo, filterSwitchThree;
    logic [FN_W-1:0] functionBits;
    logic [PD_W-1:0] powerDownBits;
    logic [MUX_W-1:0] outputMuxBits;
    logic [TST_W-1:0] testBits;
    logic [2:0] refPhase = 3'h0;
    int failures = 0, checked = 0, cycles = 0;

    spr_program_regs dut (.clk(clk), .arst_n(arst_n), .serialClk(serialClk),
        .serialData(serialData), .loadStrobe(loadStrobe),
        .referenceInput(referenceInput), .divInt(divInt), .divFrac(divFrac),
        .divModulus(divModulus), .phaseSeed(phaseSeed), .divLoad(divLoad),
        .refCount(refCount), .refDoubler(refDoubler), .refHalve(refHalve),
        .prescalerSel(prescalerSel), .pfdTick(pfdTick),
        .pumpCells(pumpCells), .pumpBoost(pumpBoost),
        .filterSwitchOne(filterSwitchOne), .filterSwitchTwo(filterSwitchTwo),
        .filterSwitchThree(filterSwitchThree), .functionBits(functionBits),
        .powerDownBits(powerDownBits), .outputMuxBits(outputMuxBits),
        .testBits(testBits));
    spr_host_model host (.serialClk(serialClk), .serialData(serialData),
        .loadStrobe(loadStrobe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Reference toggles every 8 cycles, a 16-cycle period
    always @(posedge clk) begin
        refPhase <= refPhase + 3'h1;
        if (refPhase == 3'h7) begin
            referenceInput <= ~referenceInput;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            results();
        end
    end

    function automatic logic [23:0] chanW(input logic [7:0] n,
        input logic [11:0] f);
        return {1'b0, n, f, 3'h0};
    endfunction : chanW
    function automatic logic [23:0] modW(input logic b, input logic h,
        input logic p, input logic d, input logic [3:0] r, input logic [11:0] m);
        return {b, h, 1'b0, p, d, r, m, 3'h1};
    endfunction : modW

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic send(input logic [23:0] w);
        host.sendWord(w);
        @(negedge clk);
    endtask : send
    task automatic waitLoad(output logic prevTick, output logic [7:0] prevInt);
        int n;
        n = 0;
        prevTick = 1'b0;
        prevInt = divInt;
        @(negedge clk);
        while (divLoad !== 1'b1 && n < 3000) begin
            prevTick = pfdTick;
            prevInt = divInt;
            @(negedge clk);
            n++;
        end
        check("divLoad", 1, divLoad);
    endtask : waitLoad
    // The load pulse can come before the strobe tail ends, so watch early
    task automatic chanLoad(input logic [23:0] w, output logic pt,
        output logic [7:0] pi);
        fork
            send(w);
            waitLoad(pt, pi);
        join
    endtask : chanLoad
    task automatic tickGap(output int gap);
        int n;
        n = 0;
        gap = 0;
        while (pfdTick !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        while (pfdTick !== 1'b1 && gap < 500) begin
            @(negedge clk);
            gap++;
        end
        gap++;
    endtask : tickGap
    // Counts detector ticks until the chosen switch opens
    task automatic waitOpen(input logic one, output int ticks);
        int n;
        n = 0;
        ticks = 0;
        while ((one ? filterSwitchOne : filterSwitchTwo) !== 1'b0 && n < 5000)
        begin
            if (pfdTick === 1'b1) ticks++;
            @(negedge clk);
            n++;
        end
    endtask : waitOpen

    task automatic testReset;
        check("divInt", 8'h1A, divInt);
        check("divModulus", 12'h00D, divModulus);
        check("refCount", 4'h1, refCount);
        check("pumpCells", 7'h01, pumpCells);
        check("idleOuts", 0, {divFrac, phaseSeed, divLoad, pumpBoost, refHalve,
            refDoubler, filterSwitchOne, filterSwitchTwo, filterSwitchThree});
        $display("test reset done");
    endtask : testReset
    task automatic testStaging;
        logic pt;
        logic [7:0] pi;
        send(modW(1'b1, 1'b0, 1'b1, 1'b0, 4'h1, 12'h064));
        send({8'h00, 1'b0, 12'h123, 3'h2});
        check("stagedMod", 12'h00D, divModulus);
        check("stagedPhase", 12'h000, phaseSeed);
        check("stagedBoost", 1'b0, pumpBoost);
        chanLoad(chanW(8'h64, 12'h02A), pt, pi);
        check("tickBeforeLoad", 1'b1, pt);
        check("intBeforeLoad", 8'h1A, pi);
        check("divInt", 8'h64, divInt);
        check("divFrac", 12'h02A, divFrac);
        check("pumpCells", 7'h40, pumpCells);
        check("divModulus", 12'h064, divModulus);
        check("phaseSeed", 12'h123, phaseSeed);
        check("pumpBoost", 1'b1, pumpBoost);
        check("prescalerSel", 1'b1, prescalerSel);
        $display("test staging done");
    endtask : testStaging
    task automatic testReplace;
        logic pt;
        logic [7:0] pi;
        send(modW(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 12'h0C8));
        send(modW(1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 12'h12C));
        chanLoad(chanW(8'hC8, 12'h005), pt, pi);
        check("divModulus", 12'h12C, divModulus);
        check("pumpBoost", 1'b0, pumpBoost);
        check("divInt", 8'hC8, divInt);
        check("divFrac", 12'h005, divFrac);
        $display("test replace done");
    endtask : testReplace
    task automatic testRaw;
        logic [2:0] sels [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
        logic [12:0] pat;
        for (int i = 0; i < 4; i++) begin
            pat = 13'h1A5B ^ {i[3:0], 9'h000};
            send({8'h00, pat, sels[i]});
            case (sels[i])
                3'h3: check("functionBits", pat, functionBits);
                3'h5: check("powerDownBits", pat[4:0], powerDownBits);
                3'h6: check("outputMuxBits", pat, outputMuxBits);
                default: check("testBits", pat, testBits);
            endcase
        end
        $display("test raw done");
    endtask : testRaw
    task automatic testRefPath;
        logic [3:0] rs [4] = '{4'h2, 4'h1, 4'h1, 4'h3};
        logic dbls [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic halfs [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        int want [4] = '{32, 8, 32, 48};
        logic pt;
        logic [7:0] pi;
        int g;
        for (int i = 0; i < 4; i++) begin
            send(modW(1'b0, halfs[i], 1'b0, dbls[i], rs[i], 12'h00D));
            chanLoad(chanW(8'h1A, 12'h000), pt, pi);
            check("refCount", rs[i], refCount);
            check("refDoubler", dbls[i], refDoubler);
            check("refHalve", halfs[i], refHalve);
            tickGap(g);
            tickGap(g);
            check("tickGap", want[i], g);
        end
        $display("test refpath done");
    endtask : testRefPath
    task automatic testFastLock;
        logic pt;
        logic [7:0] pi;
        int t;
        send(modW(1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 12'h00D));
        send({10'h001, 9'h001, TSEL_ICP, 3'h4});
        send({10'h001, 9'h008, TSEL_SW1, 3'h4});
        send({10'h001, 9'h004, TSEL_SW2, 3'h4});
        send({10'h001, 9'h1FF, TSEL_NONE, 3'h4});
        chanLoad(chanW(8'h50, 12'h007), pt, pi);
        check("pumpCells", 7'h40, pumpCells);
        check("switchesClosed", 3'h7,
            {filterSwitchOne, filterSwitchTwo, filterSwitchThree});
        waitOpen(1'b0, t);
        check("swTwoTicks", 1, t >= 15 && t <= 17);
        check("swThreeOpen", 1'b0, filterSwitchThree);
        check("swOneHeld", 1'b1, filterSwitchOne);
        check("pumpStepping", 1, pumpCells >= 4 && pumpCells <= 32);
        waitOpen(1'b1, t);
        // Counted on from switch two opening: 32 minus 16 ticks remain
        check("swOneTicks", 1, t >= 15 && t <= 17);
        check("pumpNominal", 7'h01, pumpCells);
        $display("test fastlock done");
    endtask : testFastLock

    task automatic results;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        testReset();
        testStaging();
        testReplace();
        testRaw();
        testRefPath();
        testFastLock();
        results();
    end
endmodule : testbench
